// >>> tcl_pkg.sv
/*
  Constants, types and carriers of the config/lock block.
  Assumes a same-clock command decoder and a nonvolatile image at powerup.
*/
package tcl_pkg;

  // ----------------------------------------------------------------------
  // Memory banks and word locations
  // ----------------------------------------------------------------------
  localparam logic [1:0] BANK_RESERVED = 2'h0;
  localparam logic [1:0] BANK_EPC      = 2'h1;

  localparam logic [7:0] BITADDR_SAVED_CHECKSUM   = 8'h00;
  localparam logic [7:0] BITADDR_SAVED_PC         = 8'h10;
  localparam logic [7:0] WORD_SAVED_CHECKSUM      = BITADDR_SAVED_CHECKSUM >> 4;
  localparam logic [7:0] WORD_SAVED_PC            = BITADDR_SAVED_PC >> 4;
  localparam logic [7:0] WORD_USER_CONFIG         = 8'h04;
  localparam logic [7:0] WORD_TUNING_VALUE        = 8'h14;
  localparam logic [7:0] WORD_PW_LAST             = 8'h03;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_SHORT_RANGE_POS = 4;
  localparam int CFG_MAP_SEL_POS     = 3;
  localparam int CFG_TUNE_DIS_POS    = 0;
  localparam int PC_LEN_MSB          = 15;
  localparam int PC_LEN_LSB          = 11;
  localparam int PC_USER_FLAG_POS    = 10;
  localparam int PC_EXT_FLAG_POS     = 9;
  localparam int PC_TOGGLE_POS       = 8;
  localparam int PC_AFC_MSB          = 7;
  localparam int LOCK_KILL_MASK_MSB  = 19;
  localparam int LOCK_ACC_MASK_MSB   = 17;
  localparam int LOCK_KILL_ACT_MSB   = 9;
  localparam int LOCK_ACC_ACT_MSB    = 7;

  // ----------------------------------------------------------------------
  // Reset values, codes and sizes
  // ----------------------------------------------------------------------
  localparam logic [15:0] PC_DEFAULT_NO_USER  = 16'h3000;
  localparam logic [15:0] PC_DEFAULT_USER     = 16'h3400;
  localparam logic [4:0]  PC_LEN_DEFAULT      = 5'h06;
  localparam logic [7:0]  ERR_NOT_SUPPORTED   = 8'h01;
  localparam logic [7:0]  ERR_MEM_LOCKED      = 8'h04;
  localparam logic [7:0]  ERR_OTHER           = 8'h00;
  localparam logic [1:0]  RANGE_NORMAL        = 2'h0;
  localparam logic [1:0]  RANGE_TOGGLE        = 2'h1;
  localparam logic [1:0]  RANGE_SHORT         = 2'h2;
  localparam logic [2:0]  TUNE_MIDRANGE       = 3'h2;
  localparam logic [15:0] CRC_PRESET          = 16'hFFFF;
  localparam logic [15:0] CRC_POLY            = 16'h1021;
  localparam int          EPC_WORDS_MAX       = 8;
  localparam logic [4:0]  EPC_WORDS_BIG_MAP   = 5'h08;
  localparam logic [4:0]  EPC_WORDS_SMALL_MAP = 5'h06;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_LOCK, OP_UNTRACE} tcl_op_t;

  typedef struct packed {
    logic        valid;
    tcl_op_t     op;
    logic [1:0]  bank;
    logic [7:0]  word;
    logic [15:0] data;
    logic [19:0] payload;
    logic [1:0]  range;
  } tcl_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        ok;
    logic [7:0]  err;
    logic [15:0] data;
  } tcl_resp_t;

  typedef struct packed {
    logic        short_range_bit;
    logic        map_sel;
    logic        map_frozen;
    logic        tune_disable;
    logic        pw_locked;
    logic        pw_perma;
    logic [15:0] saved_protocol_control;
  } tcl_nv_t;

  typedef struct packed {
    logic        valid;
    logic [19:0] payload;
  } tcl_lock_t;

  localparam tcl_nv_t NV_FACTORY = '{short_range_bit: 1'b0, map_sel: 1'b0,
    map_frozen: 1'b0, tune_disable: 1'b0, pw_locked: 1'b0, pw_perma: 1'b0,
    saved_protocol_control: PC_DEFAULT_USER};

endpackage : tcl_pkg

// >>> tcl_config_lock.sv
/*
  Tag configuration and password lock logic, powerup checksum and
  protocol-control word layout.
  Assumes same-clock decoded commands and secured state; stable
  nonvolatile image and EPC words during powerup.
*/
//
// Operation
// - Payloads A0000, F0140 unlock password for open or secured access.
// - Payload A0280: password access only when secured.
// - Payload F03C0 refuses all later password access.
// - One Lock may also lock other banks when password pairs match.
// - Invalid Lock payload changes nothing; reply error not supported.
// - Short-range bit changes only when secured with nonzero password.
// - Short-range bit factory zero; one asserts reduced sensitivity.
// - Untraceable range 10 stores one, 00 stores zero, when authorised.
// - Range 01 keeps stored bit, inverts it through volatile flag.
// - Map bit one: 128-bit EPC, no user; zero: 96-bit EPC, 32-bit user.
// - Map bit written once, secured only; later writes keep it.
// - Any accepted Lock permanently freezes the map bit.
// - Tuning-disable one forces midrange capacitance; zero re-enables.
// - Word 14h read returns powerup tuning value; writes ignored.
// - Tuning codes 0..4 mean -100, -40, 0, +40, +100 fF.
// - Readback shows chosen tuning value even while tuning disabled.
// - EPC bank: checksum at 00h, protocol-control at 10h, EPC from 20h.
// - Every powerup recomputes checksum over PC and L-sized EPC.
// - Length bits 10h-14h writable, default selects 96-bit EPC.
// - User-memory flag reads 0 without user memory, 1 with it.
// - Extended-PC flag fixed zero; no extended word provided.
// - Toggle bit writable; spare bits zero at 0, family code at 1.
// - Secured state entered only after correct Access sequence.
// - Word 4 rewrites accepted but committed map bit kept.
`timescale 1ns/1ps

module tcl_config_lock
  import tcl_pkg::*;
#(
  parameter int EPC_WORDS = tcl_pkg::EPC_WORDS_MAX
) (
  // Clock and powerup reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      reset_n_in,
  // Decoded reader commands and tag state
  input  wire tcl_pkg::tcl_cmd_t         cmd_in,
  input  wire logic                      secured_in,
  input  wire logic                      access_pw_nonzero_in,
  // Nonvolatile image and EPC contents
  input  wire tcl_pkg::tcl_nv_t          nv_image_in,
  input  wire logic [EPC_WORDS*16-1:0]   epc_words_in,
  // Analog tuner result
  input  wire logic [2:0]                tune_code_in,
  // Replies and forwarded actions
  output tcl_pkg::tcl_resp_t             resp_out,
  output logic                           pw_grant_out,
  output tcl_pkg::tcl_lock_t             lock_fwd_out,
  output tcl_pkg::tcl_nv_t               nv_image_out,
  output logic [15:0]                    saved_checksum_out,
  output logic                           ready_out,
  // Analog and memory-map controls
  output logic                           reduced_sens_out,
  output logic                           tune_disable_out,
  output logic [2:0]                     cap_code_out,
  output logic                           epc_128_out,
  output logic                           user_mem_out
);
  import tcl_pkg::*;

  // ----------------------------------------------------------------------
  // Powerup sequence
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_LOAD, ST_CRC, ST_RUN} tcl_state_t;

  tcl_state_t  state;
  tcl_nv_t     nv;
  logic        sr_invert;
  logic [2:0]  tune_meta;
  logic [2:0]  tune_sync;
  logic [2:0]  tune_value;
  logic [15:0] crc;
  logic [4:0]  crc_idx;
  logic [4:0]  crc_words;

  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction : crc_word

  // Length field clamped to what the chosen map can hold
  always_comb begin
    crc_words = nv.saved_protocol_control[PC_LEN_MSB:PC_LEN_LSB];
    if (nv.map_sel && crc_words > EPC_WORDS_BIG_MAP) begin
      crc_words = EPC_WORDS_BIG_MAP;
    end else if (!nv.map_sel && crc_words > EPC_WORDS_SMALL_MAP) begin
      crc_words = EPC_WORDS_SMALL_MAP;
    end
  end

  // Tuner output is analog-side, so it is synchronised first
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tune_meta <= TUNE_MIDRANGE;
      tune_sync <= TUNE_MIDRANGE;
    end else begin
      tune_meta <= tune_code_in;
      tune_sync <= tune_meta;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state   <= ST_LOAD;
      crc     <= CRC_PRESET;
      crc_idx <= '0;
    end else begin
      case (state)
        ST_LOAD: begin
          crc     <= crc_word(CRC_PRESET, nv_image_in.saved_protocol_control);
          crc_idx <= '0;
          state   <= ST_CRC;
        end
        ST_CRC: begin
          if (crc_idx >= crc_words || crc_idx >= 5'(EPC_WORDS)) begin
            state <= ST_RUN;
          end else begin
            crc     <= crc_word(crc, epc_words_in[(EPC_WORDS-1-int'(crc_idx))*16 +: 16]);
            crc_idx <= crc_idx + 5'h01;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      saved_checksum_out <= '0;
      ready_out          <= 1'b0;
      tune_value         <= TUNE_MIDRANGE;
    end else begin
      if (!ready_out) begin
        tune_value <= tune_sync;
      end
      if (state == ST_CRC && (crc_idx >= crc_words || crc_idx >= 5'(EPC_WORDS))) begin
        saved_checksum_out <= ~crc;
        ready_out          <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  logic       cmd_go;
  logic       is_pw_word;
  logic       pw_ok;
  logic       auth_ok;
  logic       lock_valid;
  logic [1:0] kill_mask;
  logic [1:0] acc_mask;
  logic [1:0] kill_act;
  logic [1:0] acc_act;
  logic [15:0] cfg_word;
  logic [15:0] pc_word;

  assign cmd_go     = cmd_in.valid && state == ST_RUN;
  assign is_pw_word = cmd_in.bank == BANK_RESERVED && cmd_in.word <= WORD_PW_LAST;
  // Secured only reachable through the engine's Access sequence
  assign auth_ok    = secured_in && access_pw_nonzero_in;
  assign pw_ok      = nv.pw_perma ? !nv.pw_locked : (!nv.pw_locked || secured_in);
  assign kill_mask  = cmd_in.payload[LOCK_KILL_MASK_MSB -: 2];
  assign acc_mask   = cmd_in.payload[LOCK_ACC_MASK_MSB -: 2];
  assign kill_act   = cmd_in.payload[LOCK_KILL_ACT_MSB -: 2];
  assign acc_act    = cmd_in.payload[LOCK_ACC_ACT_MSB -: 2];
  assign lock_valid = kill_mask == acc_mask && kill_act == acc_act;

  always_comb begin
    cfg_word = '0;
    cfg_word[CFG_SHORT_RANGE_POS] = nv.short_range_bit;
    cfg_word[CFG_MAP_SEL_POS]     = nv.map_sel;
    cfg_word[CFG_TUNE_DIS_POS]    = nv.tune_disable;
    pc_word = nv.saved_protocol_control;
    pc_word[PC_USER_FLAG_POS] = !nv.map_sel;
    pc_word[PC_EXT_FLAG_POS]  = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Stored configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nv <= NV_FACTORY;
    end else if (state == ST_LOAD) begin
      nv <= nv_image_in;
    end else if (cmd_go) begin
      case (cmd_in.op)
        OP_WRITE: begin
          if (cmd_in.bank == BANK_RESERVED && cmd_in.word == WORD_USER_CONFIG && secured_in
              && (auth_ok || cmd_in.data[CFG_SHORT_RANGE_POS] == nv.short_range_bit)) begin
            nv.short_range_bit <= cmd_in.data[CFG_SHORT_RANGE_POS];
            nv.tune_disable    <= cmd_in.data[CFG_TUNE_DIS_POS];
            if (!nv.map_frozen) begin
              nv.map_sel    <= cmd_in.data[CFG_MAP_SEL_POS];
              nv.map_frozen <= 1'b1;
            end
          end else if (cmd_in.bank == BANK_EPC && cmd_in.word == WORD_SAVED_PC) begin
            nv.saved_protocol_control[PC_LEN_MSB:PC_LEN_LSB] <= cmd_in.data[PC_LEN_MSB:PC_LEN_LSB];
            nv.saved_protocol_control[PC_TOGGLE_POS] <= cmd_in.data[PC_TOGGLE_POS];
            nv.saved_protocol_control[PC_AFC_MSB:0] <=
              cmd_in.data[PC_TOGGLE_POS] ? cmd_in.data[PC_AFC_MSB:0] : '0;
          end
        end
        OP_LOCK: begin
          if (lock_valid && !(nv.pw_perma && kill_mask != 2'h0)) begin
            nv.map_frozen <= 1'b1;
            if (kill_mask[1]) begin
              nv.pw_locked <= kill_act[1];
            end
            if (kill_mask[0]) begin
              nv.pw_perma <= kill_act[0];
            end
          end
        end
        OP_UNTRACE: begin
          if (auth_ok && cmd_in.range == RANGE_SHORT) begin
            nv.short_range_bit <= 1'b1;
          end else if (auth_ok && cmd_in.range == RANGE_NORMAL) begin
            nv.short_range_bit <= 1'b0;
          end
        end
        default: begin
          nv <= nv;
        end
      endcase
    end
  end

  // Volatile inversion, lost with power
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sr_invert <= 1'b0;
    end else if (cmd_go && cmd_in.op == OP_UNTRACE && auth_ok && cmd_in.range == RANGE_TOGGLE) begin
      sr_invert <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Replies and forwarded actions
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resp_out     <= '0;
      pw_grant_out <= 1'b0;
      lock_fwd_out <= '0;
    end else begin
      resp_out     <= '0;
      pw_grant_out <= 1'b0;
      lock_fwd_out <= '0;
      if (cmd_go) begin
        case (cmd_in.op)
          OP_READ, OP_WRITE: begin
            if (is_pw_word) begin
              resp_out.valid <= 1'b1;
              resp_out.ok    <= pw_ok;
              resp_out.err   <= pw_ok ? ERR_OTHER : ERR_MEM_LOCKED;
              pw_grant_out   <= pw_ok;
            end else if (cmd_in.bank == BANK_RESERVED && cmd_in.word == WORD_USER_CONFIG) begin
              resp_out.valid <= 1'b1;
              resp_out.data  <= cfg_word;
              resp_out.ok    <= cmd_in.op == OP_READ || (secured_in
                                && (auth_ok || cmd_in.data[CFG_SHORT_RANGE_POS] == nv.short_range_bit));
              resp_out.err   <= ERR_MEM_LOCKED;
            end else if (cmd_in.bank == BANK_RESERVED && cmd_in.word == WORD_TUNING_VALUE) begin
              resp_out.valid <= 1'b1;
              resp_out.ok    <= 1'b1;
              resp_out.data  <= {13'h0000, tune_value};
            end else if (cmd_in.bank == BANK_EPC && cmd_in.word == WORD_SAVED_CHECKSUM) begin
              resp_out.valid <= 1'b1;
              resp_out.ok    <= cmd_in.op == OP_READ;
              resp_out.err   <= ERR_MEM_LOCKED;
              resp_out.data  <= saved_checksum_out;
            end else if (cmd_in.bank == BANK_EPC && cmd_in.word == WORD_SAVED_PC) begin
              resp_out.valid <= 1'b1;
              resp_out.ok    <= 1'b1;
              resp_out.data  <= pc_word;
            end
          end
          OP_LOCK: begin
            resp_out.valid <= 1'b1;
            resp_out.ok    <= lock_valid && !(nv.pw_perma && kill_mask != 2'h0);
            resp_out.err   <= lock_valid ? ERR_MEM_LOCKED : ERR_NOT_SUPPORTED;
            lock_fwd_out.valid   <= lock_valid && !(nv.pw_perma && kill_mask != 2'h0);
            lock_fwd_out.payload <= cmd_in.payload;
          end
          OP_UNTRACE: begin
            resp_out.valid <= 1'b1;
            resp_out.ok    <= auth_ok;
            resp_out.err   <= ERR_OTHER;
          end
          default: begin
            resp_out <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Analog and map controls
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reduced_sens_out <= 1'b0;
      tune_disable_out <= 1'b0;
      cap_code_out     <= TUNE_MIDRANGE;
      epc_128_out      <= 1'b0;
      user_mem_out     <= 1'b1;
      nv_image_out     <= NV_FACTORY;
    end else begin
      reduced_sens_out <= nv.short_range_bit ^ sr_invert;
      tune_disable_out <= nv.tune_disable;
      // Applied step is midrange when disabled, code 2 is no change
      cap_code_out     <= nv.tune_disable ? TUNE_MIDRANGE : tune_value;
      epc_128_out      <= nv.map_sel;
      user_mem_out     <= !nv.map_sel;
      nv_image_out     <= nv;
    end
  end

endmodule : tcl_config_lock

// >>> tcl_config_lock_chk.sv
/*
  Port checks of the config/lock block.
  Assumes binding onto tcl_config_lock.
*/
`timescale 1ns/1ps

module tcl_config_lock_chk
  import tcl_pkg::*;
(
  // Clock and reset
  input wire logic               clk_sys_in,
  input wire logic               reset_n_in,
  // Watched ports
  input wire tcl_pkg::tcl_cmd_t  cmd_in,
  input wire logic               secured_in,
  input wire logic               access_pw_nonzero_in,
  input wire tcl_pkg::tcl_resp_t resp_out,
  input wire tcl_pkg::tcl_lock_t lock_fwd_out,
  input wire tcl_pkg::tcl_nv_t   nv_image_out,
  input wire logic               ready_out,
  input wire logic               tune_disable_out,
  input wire logic [2:0]         cap_code_out,
  input wire logic               epc_128_out,
  input wire logic               user_mem_out
);
  import tcl_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  logic bad_lock;
  logic tune_rd;
  assign bad_lock = cmd_in.valid && ready_out && cmd_in.op == OP_LOCK &&
    (cmd_in.payload[LOCK_KILL_MASK_MSB -: 2] != cmd_in.payload[LOCK_ACC_MASK_MSB -: 2] ||
     cmd_in.payload[LOCK_KILL_ACT_MSB -: 2] != cmd_in.payload[LOCK_ACC_ACT_MSB -: 2]);
  assign tune_rd = cmd_in.valid && ready_out && cmd_in.op == OP_READ &&
    cmd_in.bank == BANK_RESERVED && cmd_in.word == WORD_TUNING_VALUE;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_bad_lock_err:
    assert property (bad_lock |=> resp_out.valid && !resp_out.ok && resp_out.err == ERR_NOT_SUPPORTED)
      else $error("bad lock reply wrong");
  a_bad_lock_nofwd:
    assert property (bad_lock |=> !lock_fwd_out.valid)
      else $error("bad lock forwarded");
  a_cap_mid_dis:
    assert property (tune_disable_out |-> cap_code_out == TUNE_MIDRANGE)
      else $error("cap not midrange");
  a_map_user_excl:
    assert property (epc_128_out != user_mem_out)
      else $error("map outputs clash");
  a_sr_needs_auth:
    assert property (ready_out && $past(ready_out, 2) && $changed(nv_image_out.short_range_bit)
      |-> $past(secured_in, 2) && $past(access_pw_nonzero_in, 2))
      else $error("unauthorised range change");
  a_map_frozen_hold:
    assert property (nv_image_out.map_frozen && $past(nv_image_out.map_frozen) |-> $stable(nv_image_out.map_sel))
      else $error("frozen map bit changed");
  a_ext_flag_zero:
    assert property (ready_out |-> !nv_image_out.saved_protocol_control[PC_EXT_FLAG_POS])
      else $error("extended pc flag set");
  a_spare_zero:
    assert property (ready_out && !nv_image_out.saved_protocol_control[PC_TOGGLE_POS]
      |-> nv_image_out.saved_protocol_control[PC_AFC_MSB:0] == 8'h00)
      else $error("spare bits set");
  a_tune_read:
    assert property (tune_rd |=> resp_out.valid && resp_out.ok &&
      (tune_disable_out || resp_out.data[2:0] == cap_code_out))
      else $error("tune readback wrong");
  a_resp_cause:
    assert property (resp_out.valid |-> $past(cmd_in.valid))
      else $error("stray reply");
endmodule : tcl_config_lock_chk

bind tcl_config_lock tcl_config_lock_chk tcl_config_lock_chk_i (.clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in), .cmd_in(cmd_in), .secured_in(secured_in),
  .access_pw_nonzero_in(access_pw_nonzero_in), .resp_out(resp_out), .lock_fwd_out(lock_fwd_out),
  .nv_image_out(nv_image_out), .ready_out(ready_out), .tune_disable_out(tune_disable_out),
  .cap_code_out(cap_code_out), .epc_128_out(epc_128_out), .user_mem_out(user_mem_out));

// >>> tcl_reader_model.sv
/*
  Behavioural reader on the far side: issues one decoded command at a time.
  Assumes the block answers on the edge after the command.
*/
`timescale 1ns/1ps

module tcl_reader_model
  import tcl_pkg::*;
(
  // Clock
  input  wire logic               clk_sys_in,
  // Command side
  output tcl_pkg::tcl_cmd_t       cmd_out,
  output logic                    secured_out,
  output logic                    pw_nonzero_out,
  input  wire tcl_pkg::tcl_resp_t resp_in
);
  import tcl_pkg::*;
  initial begin
    cmd_out        = '0;
    secured_out    = 1'b0;
    pw_nonzero_out = 1'b0;
  end

  // Secured only after a correct access sequence
  task automatic auth(input logic sec, input logic nz);
    @(posedge clk_sys_in);
    #1;
    secured_out    = sec;
    pw_nonzero_out = nz;
  endtask : auth

  // All word 4 bits go in one write; idle fields scrambled
  task automatic send(input tcl_op_t op, input logic [1:0] bank, input logic [7:0] word,
                      input logic [15:0] data, input logic [19:0] pl, input logic [1:0] rg,
                      output tcl_resp_t r);
    tcl_cmd_t t;
    @(posedge clk_sys_in);
    #1;
    cmd_out = '{valid: 1'b1, op: op, bank: bank, word: word, data: data, payload: pl, range: rg};
    @(posedge clk_sys_in);
    #1;
    r       = resp_in;
    t       = ~cmd_out;
    t.valid = 1'b0;
    cmd_out = t;
  endtask : send
endmodule : tcl_reader_model

// >>> tcl_config_lock_bench.sv
/*
  Self-checking bench for the config/lock block.
  Assumes the reader model drives all command inputs.
*/
`timescale 1ns/1ps

module tcl_config_lock_bench;
  import tcl_pkg::*;
  localparam logic [127:0] EPC = 128'h1234_ABCD_0F0F_5A5A_C3C3_7E81_9999_0001;

  logic clk_sys_in, reset_n_in, pw_grant, ready, red, tdis, e128, umem;
  logic [2:0]  cap;
  logic [15:0] crc;
  tcl_cmd_t  cmd;
  tcl_resp_t resp, rsp;
  tcl_lock_t fwd;
  tcl_nv_t   nv;
  logic secured, pw_nz;
  int error_cnt, samples_checked;

  tcl_config_lock tcl_config_lock_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cmd_in(cmd),
    .secured_in(secured), .access_pw_nonzero_in(pw_nz), .nv_image_in(NV_FACTORY), .epc_words_in(EPC),
    .tune_code_in(3'h3), .resp_out(resp), .pw_grant_out(pw_grant), .lock_fwd_out(fwd),
    .nv_image_out(nv), .saved_checksum_out(crc), .ready_out(ready), .reduced_sens_out(red),
    .tune_disable_out(tdis), .cap_code_out(cap), .epc_128_out(e128), .user_mem_out(umem));
  tcl_reader_model tcl_reader_model_i (.clk_sys_in(clk_sys_in), .cmd_out(cmd), .secured_out(secured),
    .pw_nonzero_out(pw_nz), .resp_in(resp));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic go(input tcl_op_t op, input logic [1:0] b, input logic [7:0] w, input logic [15:0] d = 16'h0,
                    input logic [19:0] p = 20'h0, input logic [1:0] r = 2'h0);
    tcl_reader_model_i.send(op, b, w, d, p, r, rsp);
  endtask : go

  task automatic ut(input logic [1:0] r);
    go(OP_UNTRACE, BANK_RESERVED, 8'h00, 16'h0, 20'h0, r);
  endtask : ut

  task automatic au(input logic s, input logic n);
    tcl_reader_model_i.auth(s, n);
  endtask : au

  function automatic logic [15:0] ctl();
    return {3'h0, red, 3'h0, tdis, 1'b0, cap, 2'h0, e128, umem};
  endfunction : ctl

  task automatic settle;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask : settle

  task automatic do_reset;
    reset_n_in = 1'b0;
    #20;
    @(posedge clk_sys_in);
    #1;
    reset_n_in = 1'b1;
    for (int i = 0; i < 40 && ready !== 1'b1; i++) @(posedge clk_sys_in);
    chk("ready", 16'h1, {15'h0, ready});
    @(posedge clk_sys_in);
  endtask : do_reset

  function automatic logic [15:0] crc_calc(input logic [15:0] pc, input logic [127:0] e);
    logic [111:0] s;
    logic [15:0]  c;
    s = {pc, e[127 -: 96]};
    c = CRC_PRESET;
    for (int b = 111; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ s[b]) ? CRC_POLY : 16'h0);
    return ~c;
  endfunction : crc_calc

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    reset_n_in = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    do_reset;
    chk("crc", crc_calc(PC_DEFAULT_USER, EPC), crc);
    go(OP_READ, BANK_EPC, WORD_SAVED_PC);
    chk("pc", 16'h3400, rsp.data);
    chk("ctl", 16'h0031, ctl());
    go(OP_WRITE, BANK_RESERVED, WORD_TUNING_VALUE, 16'h0004);
    go(OP_READ, BANK_RESERVED, WORD_TUNING_VALUE);
    chk("tune", 16'h0003, rsp.data);
    au(1'b0, 1'b1);
    go(OP_WRITE, BANK_RESERVED, WORD_USER_CONFIG, 16'h0011);
    chk("w4 open", 16'h0, {15'h0, rsp.ok});
    au(1'b1, 1'b0);
    go(OP_WRITE, BANK_RESERVED, WORD_USER_CONFIG, 16'h0010);
    chk("w4 pw0", 16'h0, {15'h0, rsp.ok});
    au(1'b1, 1'b1);
    go(OP_WRITE, BANK_RESERVED, WORD_USER_CONFIG, 16'h0011);
    settle;
    chk("w4 set", 16'h1121, ctl());
    go(OP_READ, BANK_RESERVED, WORD_TUNING_VALUE);
    chk("tune dis", 16'h0003, rsp.data);
    go(OP_WRITE, BANK_RESERVED, WORD_USER_CONFIG, 16'h0008);
    settle;
    chk("w4 again", 16'h0031, ctl());
    au(1'b0, 1'b1);
    ut(RANGE_SHORT);
    chk("untr open", 16'h0, {7'h0, rsp.ok, rsp.err});
    au(1'b1, 1'b1);
    ut(RANGE_SHORT);
    settle;
    chk("untr 10", 16'h1, {15'h0, red});
    ut(RANGE_NORMAL);
    settle;
    chk("untr 00", 16'h0, {15'h0, red});
    ut(RANGE_TOGGLE);
    settle;
    chk("untr 01", 16'h10, {11'h0, red, 3'h0, nv.short_range_bit});
    go(OP_WRITE, BANK_EPC, WORD_SAVED_PC, 16'h30FF);
    go(OP_READ, BANK_EPC, WORD_SAVED_PC);
    chk("pc t0", 16'h3400, rsp.data);
    go(OP_WRITE, BANK_EPC, WORD_SAVED_PC, 16'h33AB);
    go(OP_READ, BANK_EPC, WORD_SAVED_PC);
    chk("pc t1", 16'h35AB, rsp.data);
    go(OP_LOCK, BANK_RESERVED, 8'h00, 16'h0, 20'hA0040);
    chk("lock bad", {8'h0, ERR_NOT_SUPPORTED}, {7'h0, rsp.ok, rsp.err});
    go(OP_LOCK, BANK_RESERVED, 8'h00, 16'h0, 20'hA0280);
    chk("lock fwd", 16'h1, {15'h0, fwd.valid});
    au(1'b0, 1'b1);
    go(OP_READ, BANK_RESERVED, 8'h02);
    chk("pw open", {8'h0, ERR_MEM_LOCKED}, {7'h0, rsp.ok, rsp.err});
    au(1'b1, 1'b1);
    go(OP_READ, BANK_RESERVED, 8'h02);
    chk("pw sec", 16'h3, {14'h0, rsp.ok, pw_grant});
    go(OP_LOCK, BANK_RESERVED, 8'h00, 16'h0, 20'hA0000);
    au(1'b0, 1'b1);
    go(OP_WRITE, BANK_RESERVED, 8'h03);
    chk("pw unl", 16'h3, {14'h0, rsp.ok, pw_grant});
    go(OP_LOCK, BANK_RESERVED, 8'h00, 16'h0, 20'hF03C0);
    au(1'b1, 1'b1);
    go(OP_READ, BANK_RESERVED, 8'h00);
    chk("pw perma", 16'h0, {14'h0, rsp.ok, pw_grant});
    go(OP_LOCK, BANK_RESERVED, 8'h00, 16'h0, 20'hF0140);
    chk("relock", {8'h0, ERR_MEM_LOCKED}, {7'h0, rsp.ok, rsp.err});
    do_reset;
    chk("volatile", 16'h0, {15'h0, red});
    go(OP_LOCK, BANK_EPC, 8'h00, 16'h0, 20'hF0140);
    au(1'b0, 1'b1);
    go(OP_READ, BANK_RESERVED, 8'h02);
    chk("pw perm unl", 16'h3, {14'h0, rsp.ok, pw_grant});
    au(1'b1, 1'b1);
    go(OP_WRITE, BANK_RESERVED, WORD_USER_CONFIG, 16'h0008);
    settle;
    chk("map frozen", 16'h01, {14'h0, e128, umem});
    end_sim;
  end

  initial begin
    #200000;
    error_cnt++;
    end_sim;
  end
endmodule : tcl_config_lock_bench
